// *** rx_los_pkg.sv ***
/*
 * Constants for the receive-section interrupt logic of one E3 framer
 * channel: register offsets, field positions, reset values and line
 * run lengths.
 * Assumes 8-bit registers on a plain strobe port.
 */
`default_nettype none
package rx_los_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // register offsets
   localparam logic [7:0] OFS_BLK_IE   = 8'h04;
   localparam logic [7:0] OFS_RX_CFG   = 8'h11;
   localparam logic [7:0] OFS_RX_IE1   = 8'h12;
   localparam logic [7:0] OFS_RX_IE2   = 8'h13;
   localparam logic [7:0] OFS_RX_ST1   = 8'h14;
   localparam logic [7:0] OFS_RX_ST2   = 8'h15;
   localparam logic [7:0] OFS_RX_CLR1  = 8'h16;
   localparam logic [7:0] OFS_RX_CLR2  = 8'h17;

   // field positions
   localparam int BIT_BLK_RX   = 7;
   localparam int BIT_BLK_TX   = 1;
   localparam int BIT_BLK_SEC  = 0;
   localparam int BIT_CFG_ALGO = 7;
   localparam int BIT_CFG_LOSS = 4;

   // source positions in the combined source vector
   localparam int SRC_AIS   = 0;
   localparam int SRC_LOSS  = 1;
   localparam int SRC_LOF   = 2;
   localparam int SRC_OOF   = 3;
   localparam int SRC_ALIGN = 4;
   localparam int SRC_NUM   = 10;
   localparam int SRC_ONE_W = 5;
   localparam int SRC_TWO_W = 5;

   // reset values
   localparam logic [7:0] RST_BLK_IE = 8'h00;
   localparam logic [4:0] RST_RX_IE  = 5'h00;
   localparam logic       RST_ALGO   = 1'b0;
   localparam logic [7:0] RST_RDATA  = 8'h00;

   // line run lengths, in line bits
   localparam int ZERO_RUN_LEN = 32;
   localparam int CLEAN_SPAN   = 32;
   localparam int QUIET_RUN    = 4;
endpackage
`default_nettype wire

// *** rx_e3_los_interrupt_logic.sv ***
/*
 * Receive-section interrupt logic of one E3 framer channel: loss of
 * signal detection from the line interface pin and the line rails,
 * sticky status, source and block enables, one active-low request.
 * Assumes all inputs synchronous to mclk, one line bit per cycle with
 * line_bit_valid high, other source events as one-cycle pulses.
 */
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module rx_e3_los_interrupt_logic
#(
   parameter int ZERO_RUN = rx_los_pkg::ZERO_RUN_LEN,
   parameter int CLEAN    = rx_los_pkg::CLEAN_SPAN,
   parameter int QUIET    = rx_los_pkg::QUIET_RUN
)
(
   input  wire logic                          mclk,
   input  wire logic                          rst_n,
   input  wire logic [rx_los_pkg::ADDR_W-1:0] addr,
   input  wire logic [rx_los_pkg::DATA_W-1:0] wdata,
   input  wire logic                          wr_en,
   input  wire logic                          rd_en,
   output logic      [rx_los_pkg::DATA_W-1:0] rdata,
   input  wire logic                          line_loss_indicator_in,
   input  wire logic                          rx_line_positive_rail,
   input  wire logic                          rx_line_negative_rail,
   input  wire logic                          line_bit_valid,
   input  wire logic [3:0]                    one_events_in,
   input  wire logic [4:0]                    two_events_in,
   output logic                               signal_loss_state_flag,
   output logic                               irq_n
);
   import rx_los_pkg::*;

   localparam int CNT_W = $clog2(ZERO_RUN + CLEAN + 1);
   localparam logic [CNT_W-1:0] ZERO_LAST = CNT_W'(ZERO_RUN - 1);
   localparam logic [CNT_W-1:0] CLEAN_LAST = CNT_W'(CLEAN - 1);
   localparam logic [CNT_W-1:0] QUIET_LAST = CNT_W'(QUIET - 1);

   // a quiet run longer than the zero run would never restart the clean span
   if (ZERO_RUN < 2 || CLEAN < 2 || QUIET < 1 || QUIET > CLEAN
       || QUIET > ZERO_RUN)
   begin : g_bad_runs
      $error("rx_e3_los_interrupt_logic: bad run length parameters");
   end

   logic [7:0]         blk_ie;
   logic               algo_sel;
   logic [SRC_NUM-1:0] src_en;
   logic [SRC_NUM-1:0] stat;
   logic [SRC_NUM-1:0] ev;
   logic [SRC_NUM-1:0] clr;
   logic [CNT_W-1:0]   zero_run;
   logic [CNT_W-1:0]   clean_cnt;
   logic               pin_q;
   logic               zero_bit;
   logic               zero_hit;
   logic               quiet_hit;
   logic               clean_hit;
   logic               declare;
   logic               release_loss;
   logic               next_loss;
   logic               loss_event;
   logic               blk_rx;

   assign blk_rx = blk_ie[BIT_BLK_RX];

   // line run detection
   assign zero_bit  = ~rx_line_positive_rail & ~rx_line_negative_rail;
   assign zero_hit  = line_bit_valid & zero_bit & (zero_run == ZERO_LAST);
   assign quiet_hit = line_bit_valid & zero_bit & (zero_run >= QUIET_LAST);
   assign clean_hit = line_bit_valid & ~quiet_hit
                      & (clean_cnt == CLEAN_LAST);

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         zero_run <= '0;
      else if (line_bit_valid)
      begin
         if (!zero_bit)
            zero_run <= '0;
         else if (zero_run != ZERO_LAST)
            zero_run <= zero_run + 1'b1;
      end
   end

   // bits seen since the last completed run of quiet zeros or the last full clean span
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         clean_cnt <= '0;
      else if (line_bit_valid)
      begin
         if (quiet_hit)
            clean_cnt <= '0;
         else if (clean_cnt == CLEAN_LAST)
            clean_cnt <= '0;
         else
            clean_cnt <= clean_cnt + 1'b1;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         pin_q <= 1'b0;
      else
         pin_q <= line_loss_indicator_in;
   end

   // declaration wins over clearance in the same cycle
   assign declare = line_loss_indicator_in | zero_hit;
   assign release_loss = (pin_q & ~line_loss_indicator_in)
                         | clean_hit;

   always_comb
   begin
      next_loss = signal_loss_state_flag;
      if (declare)
         next_loss = 1'b1;
      else if (release_loss)
         next_loss = 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         signal_loss_state_flag <= 1'b0;
      else
         signal_loss_state_flag <= next_loss;
   end

   // both declaration and clearance are change events
   assign loss_event = next_loss != signal_loss_state_flag;

   // combined source vector
   assign ev = {two_events_in, one_events_in[3:1],
                loss_event, one_events_in[0]};

   // status clears: read of a status register or write-one clear
   always_comb
   begin
      clr = '0;
      if (rd_en && addr == OFS_RX_ST1)
         clr[SRC_ONE_W-1:0] = '1;
      if (rd_en && addr == OFS_RX_ST2)
         clr[SRC_NUM-1:SRC_ONE_W] = '1;
      if (wr_en && addr == OFS_RX_CLR1)
         clr[SRC_ONE_W-1:0] = clr[SRC_ONE_W-1:0] | wdata[SRC_ONE_W-1:0];
      if (wr_en && addr == OFS_RX_CLR2)
         clr[SRC_NUM-1:SRC_ONE_W] = clr[SRC_NUM-1:SRC_ONE_W]
                                    | wdata[SRC_TWO_W-1:0];
   end

   // sticky status, a set beats a clear
   generate
      for (genvar i = 0; i < SRC_NUM; i++)
      begin : g_stat
         always_ff @(posedge mclk)
         begin
            if (!rst_n)
               stat[i] <= 1'b0;
            else if (ev[i] && src_en[i])
               stat[i] <= 1'b1;
            else if (clr[i])
               stat[i] <= 1'b0;
         end
      end
   endgenerate

   // register writes
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         blk_ie <= RST_BLK_IE;
      else if (wr_en && addr == OFS_BLK_IE)
      begin
         blk_ie <= '0;
         blk_ie[BIT_BLK_RX]  <= wdata[BIT_BLK_RX];
         blk_ie[BIT_BLK_TX]  <= wdata[BIT_BLK_TX];
         blk_ie[BIT_BLK_SEC] <= wdata[BIT_BLK_SEC];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         src_en <= {RST_RX_IE, RST_RX_IE};
      else
      begin
         if (wr_en && addr == OFS_RX_IE1)
            src_en[SRC_ONE_W-1:0] <= wdata[SRC_ONE_W-1:0];
         if (wr_en && addr == OFS_RX_IE2)
            src_en[SRC_NUM-1:SRC_ONE_W] <= wdata[SRC_TWO_W-1:0];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         algo_sel <= RST_ALGO;
      else if (wr_en && addr == OFS_RX_CFG)
         algo_sel <= wdata[BIT_CFG_ALGO];
   end

   // read data, valid the cycle after the read strobe only
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         rdata <= RST_RDATA;
      else if (!rd_en)
         rdata <= '0;
      else
      begin
         unique case (addr)
            OFS_BLK_IE: rdata <= blk_ie;
            OFS_RX_CFG: rdata <= {algo_sel, 2'h0,
                                  signal_loss_state_flag, 4'h0};
            OFS_RX_IE1: rdata <= {3'h0, src_en[SRC_ONE_W-1:0]};
            OFS_RX_IE2: rdata <= {3'h0, src_en[SRC_NUM-1:SRC_ONE_W]};
            OFS_RX_ST1: rdata <= {3'h0, stat[SRC_ONE_W-1:0]};
            OFS_RX_ST2: rdata <= {3'h0, stat[SRC_NUM-1:SRC_ONE_W]};
            default:    rdata <= '0;
         endcase
      end
   end

   // two-tier gating onto the request
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         irq_n <= 1'b1;
      else
         irq_n <= ~(blk_rx & |(stat & src_en));
   end

   a_pin_declares: assert property (
      @(posedge mclk) disable iff (!rst_n)
      line_loss_indicator_in |=> signal_loss_state_flag)
      else $error("loss not declared while pin high");

   a_zero_run_declares: assert property (
      @(posedge mclk) disable iff (!rst_n)
      zero_hit |=> signal_loss_state_flag)
      else $error("zero run did not declare loss");

   a_pin_low_clears: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $fell(line_loss_indicator_in) && !zero_hit |=> !signal_loss_state_flag)
      else $error("pin fall did not clear loss");

   a_clean_span_clears: assert property (
      @(posedge mclk) disable iff (!rst_n)
      clean_hit && !line_loss_indicator_in |=> !signal_loss_state_flag)
      else $error("clean span did not clear loss");

   a_loss_status_set: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $changed(signal_loss_state_flag) && $past(src_en[SRC_LOSS])
      |-> stat[SRC_LOSS])
      else $error("loss change did not set status");

   a_block_gate_off: assert property (
      @(posedge mclk) disable iff (!rst_n)
      !blk_rx |=> irq_n)
      else $error("request while block disabled");

   a_request_asserts: assert property (
      @(posedge mclk) disable iff (!rst_n)
      blk_rx && (stat[SRC_LOSS] && src_en[SRC_LOSS]) |=> !irq_n)
      else $error("qualified status did not pull request low");

   a_read_clears_status: assert property (
      @(posedge mclk) disable iff (!rst_n)
      rd_en && addr == OFS_RX_ST1 && ev[SRC_ONE_W-1:0] == '0
      |=> stat[SRC_ONE_W-1:0] == '0 ##1 irq_n || |stat)
      else $error("status read did not clear");

   a_loss_readback: assert property (
      @(posedge mclk) disable iff (!rst_n)
      rd_en && addr == OFS_RX_CFG
      |=> rdata[BIT_CFG_LOSS] == $past(signal_loss_state_flag))
      else $error("loss state readback wrong");

   a_block_enable_write: assert property (
      @(posedge mclk) disable iff (!rst_n)
      wr_en && addr == OFS_BLK_IE |=> blk_rx == $past(wdata[BIT_BLK_RX]))
      else $error("block enable write lost");

   a_source_enable_write: assert property (
      @(posedge mclk) disable iff (!rst_n)
      wr_en && addr == OFS_RX_IE1
      |=> src_en[SRC_LOSS] == $past(wdata[SRC_LOSS]))
      else $error("source enable write lost");

   a_source_gate: assert property (
      @(posedge mclk) disable iff (!rst_n)
      !src_en[SRC_LOSS] && !stat[SRC_LOSS] |=> !stat[SRC_LOSS])
      else $error("status set while source disabled");

   a_event_sets_status: assert property (
      @(posedge mclk) disable iff (!rst_n)
      one_events_in[0] && src_en[SRC_AIS] |=> stat[SRC_AIS])
      else $error("enabled event did not set status");

   a_no_source_quiet: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (stat & src_en) == '0 |=> irq_n)
      else $error("request without an enabled source");

   c_pattern_declare: cover property (
      @(posedge mclk) disable iff (!rst_n)
      zero_hit && !line_loss_indicator_in ##1 signal_loss_state_flag);

   c_pattern_clear: cover property (
      @(posedge mclk) disable iff (!rst_n)
      clean_hit && signal_loss_state_flag ##1 !signal_loss_state_flag);

   c_request_low: cover property (
      @(posedge mclk) disable iff (!rst_n)
      $fell(irq_n));

   c_read_release: cover property (
      @(posedge mclk) disable iff (!rst_n)
      !irq_n && rd_en && addr == OFS_RX_ST1 ##2 irq_n);
endmodule
`default_nettype wire

// *** line_model.sv ***
/*
 * Line side model: the loss pin and the two receive rails, one line
 * bit per cycle. Marks alternate between the rails so that no zero
 * symbol occurs; quiet sends zero symbols only.
 * Assumes one clock shared with the design.
 */
`timescale 1ns/1ps
`default_nettype none
module line_model
(
   input  wire logic mclk,
   input  wire logic quiet,
   input  wire logic pin,
   output logic      los_pin,
   output logic      pos,
   output logic      neg,
   output logic      valid
);
   logic phase = 1'b0;

   assign los_pin = pin;
   assign valid   = 1'b1;

   // phase picks the rail that carries the next mark
   always_ff @(posedge mclk)
   begin
      phase <= ~phase;
      pos   <= ~quiet & phase;
      neg   <= ~quiet & ~phase;
   end
endmodule
`default_nettype wire

// *** rx_e3_los_interrupt_logic_tb.sv ***
/*
 * Testbench for the receive loss interrupt logic: register tasks on
 * the strobe port, the line driven through line_model.
 * Assumes the design shortened to run lengths 4, 4 and 2.
 */
`timescale 1ns/1ps
`default_nettype none
module rx_e3_los_interrupt_logic_tb;
   import rx_los_pkg::*;
   logic       mclk;
   logic       rst_n;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr_en;
   logic       rd_en;
   logic [7:0] rdata;
   logic       pin;
   logic       quiet;
   logic       los_pin;
   logic       pos;
   logic       neg;
   logic       valid;
   logic [3:0] ev1;
   logic [4:0] ev2;
   logic       flag;
   logic       irq_n;
   int         miscompares;
   int         checked;

   line_model LINE (.mclk(mclk), .quiet(quiet), .pin(pin),
      .los_pin(los_pin), .pos(pos), .neg(neg), .valid(valid));

   rx_e3_los_interrupt_logic #(.ZERO_RUN(4), .CLEAN(4), .QUIET(2)) DUT (
      .mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .line_loss_indicator_in(los_pin), .rx_line_positive_rail(pos),
      .rx_line_negative_rail(neg), .line_bit_valid(valid),
      .one_events_in(ev1), .two_events_in(ev2),
      .signal_loss_state_flag(flag), .irq_n(irq_n));

   task automatic complete_run;
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic cmp8(input logic [7:0] a, input logic [7:0] e,
                       input logic [7:0] g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] reg %h exp %h got %h", a, e, g);
      end
   endtask

   task automatic cmp1(input string n, input logic e, input logic g);
      checked++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %s exp %b got %b", n, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      // read data stand for one cycle; take them at its closing edge
      @(posedge mclk);
      cmp8(a, e, rdata);
   endtask

   task automatic pulse(input logic [3:0] a, input logic [4:0] b);
      @(posedge mclk);
      ev1 <= a;
      ev2 <= b;
      @(posedge mclk);
      ev1 <= 4'h0;
      ev2 <= 5'h00;
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   initial
   begin
      #50000;
      miscompares++;
      complete_run();
   end

   initial
   begin
      {rst_n, addr, wdata, wr_en, rd_en} = '0;
      {pin, quiet, ev1, ev2} = '0;
      miscompares = 0;
      checked = 0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      cyc(1);
      cmp1("irq_n", 1'b1, irq_n);
      rd(OFS_BLK_IE, 8'h00);
      rd(OFS_RX_IE1, 8'h00);
      rd(OFS_RX_ST1, 8'h00);
      rd(OFS_RX_CFG, 8'h00);
      wr(OFS_BLK_IE, 8'hFF);
      rd(OFS_BLK_IE, 8'h83);
      wr(OFS_BLK_IE, 8'h80);
      wr(OFS_RX_IE1, 8'hFF);
      rd(OFS_RX_IE1, 8'h1F);
      wr(OFS_RX_IE1, 8'h02);
      // select bit is stored, the loss bit stays read-only
      wr(OFS_RX_CFG, 8'hFF);
      rd(OFS_RX_CFG, 8'h80);
      wr(OFS_RX_CFG, 8'h00);
      rd(8'h20, 8'h00);
      // pin driven declare and clear
      pin <= 1'b1;
      cyc(2);
      cmp1("flag", 1'b1, flag);
      cmp1("irq_n", 1'b1, irq_n);
      cyc(1);
      cmp1("irq_n", 1'b0, irq_n);
      rd(OFS_RX_CFG, 8'h10);
      rd(OFS_RX_ST1, 8'h02);
      rd(OFS_RX_ST1, 8'h00);
      cyc(1);
      cmp1("irq_n", 1'b1, irq_n);
      pin <= 1'b0;
      cyc(3);
      cmp1("flag", 1'b0, flag);
      cmp1("irq_n", 1'b0, irq_n);
      rd(OFS_RX_ST1, 8'h02);
      rd(OFS_RX_CFG, 8'h00);
      // rail content declare and clear, one model stage of delay
      quiet <= 1'b1;
      cyc(5);
      cmp1("flag", 1'b0, flag);
      cyc(1);
      cmp1("flag", 1'b1, flag);
      rd(OFS_RX_ST1, 8'h02);
      quiet <= 1'b0;
      cyc(5);
      cmp1("flag", 1'b1, flag);
      cyc(1);
      cmp1("flag", 1'b0, flag);
      rd(OFS_RX_ST1, 8'h02);
      // block and source gating
      wr(OFS_BLK_IE, 8'h00);
      pin <= 1'b1;
      cyc(3);
      cmp1("irq_n", 1'b1, irq_n);
      wr(OFS_BLK_IE, 8'h80);
      cyc(2);
      cmp1("irq_n", 1'b0, irq_n);
      rd(OFS_RX_ST1, 8'h02);
      wr(OFS_RX_IE1, 8'h00);
      pin <= 1'b0;
      cyc(3);
      cmp1("flag", 1'b0, flag);
      rd(OFS_RX_ST1, 8'h00);
      cmp1("irq_n", 1'b1, irq_n);
      // every other source kind
      wr(OFS_RX_IE1, 8'h1F);
      wr(OFS_RX_IE2, 8'h1F);
      for (int i = 0; i < 5; i++)
      begin
         pulse(4'(1 << i), 5'(1 << i));
         cyc(2);
         cmp1("irq_n", 1'b0, irq_n);
         if (i < 4)
            rd(OFS_RX_ST1, i == 0 ? 8'h01 : 8'h02 << i);
         rd(OFS_RX_ST2, 8'h01 << i);
      end
      pulse(4'h1, 5'h00);
      cyc(2);
      cmp1("irq_n", 1'b0, irq_n);
      wr(OFS_RX_CLR1, 8'h01);
      cyc(2);
      cmp1("irq_n", 1'b1, irq_n);
      rd(OFS_RX_ST1, 8'h00);
      complete_run();
   end
endmodule
`default_nettype wire
